// >>> hdl/swsm_master.sv
// Purpose: fieldbus master end driving the slave link
// Assumes: user issues one command at a time, waits for busy low
// Notes:   timing register writes go out only where enabled
`timescale 1ns/1ps
module swsm_master
   import swsm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   swsm_if.master           lnk,
   input  wire logic        cmd_reg_wr,
   input  wire logic        cmd_reg_rd,
   input  wire logic [15:0] cmd_addr,
   input  wire logic [15:0] cmd_wdata,
   input  wire logic        cmd_state,
   input  wire swsm_state_t cmd_target,
   input  wire logic        cmd_mbx,
   input  wire swsm_mbx_kind_t cmd_mbx_kind,
   input  wire logic        cmd_pd,
   input  wire logic [15:0] cmd_pd_out,
   input  wire logic        cfg_write_timing,
   output logic             busy,
   output logic [15:0]      rd_data,
   output logic             state_refused
);

   typedef struct packed {
      logic           wr;
      logic           rd;
      logic [15:0]    addr;
      logic [15:0]    wdata;
      logic           st_req;
      swsm_state_t    target;
      logic           mbx_cfg;
      logic           pd_cfg;
      logic           mbx_valid;
      swsm_mbx_kind_t kind;
      logic           pd_valid;
      logic [15:0]    pd_out;
      logic           busy;
      logic [15:0]    rdata;
      logic           refused;
   } swsm_mst_t;

   swsm_mst_t r;
   swsm_mst_t next_r;

   always_comb begin
      next_r           = r;
      next_r.wr        = 1'b0;
      next_r.rd        = 1'b0;
      next_r.st_req    = 1'b0;
      next_r.mbx_valid = 1'b0;
      next_r.pd_valid  = 1'b0;
      if (r.busy && (lnk.reg_ack || lnk.st_done)) begin
         next_r.busy = 1'b0;
         if (lnk.reg_ack) begin
            next_r.rdata = lnk.reg_rdata;
         end
         if (lnk.st_done) begin
            next_r.refused = lnk.st_refused;
         end
      end else if (!r.busy) begin
         // timing registers go out only when enabled
         if (cmd_reg_wr && (cfg_write_timing || cmd_addr < SWSM_ADDR_PRESCALER || cmd_addr > SWSM_ADDR_BUS_WD)) begin
            next_r.wr    = 1'b1;
            next_r.addr  = cmd_addr;
            next_r.wdata = cmd_wdata;
            next_r.busy  = 1'b1;
         end else if (cmd_reg_rd) begin
            next_r.rd   = 1'b1;
            next_r.addr = cmd_addr;
            next_r.busy = 1'b1;
         end else if (cmd_state) begin
            next_r.st_req = 1'b1;
            next_r.target = cmd_target;
            next_r.busy   = 1'b1;
            if (lnk.st_cur == SWSM_ST_INIT) begin
               next_r.mbx_cfg = 1'b1;
            end
            if (lnk.st_cur == SWSM_ST_CONF) begin
               next_r.pd_cfg = 1'b1;
            end
         end else if (cmd_mbx) begin
            next_r.mbx_valid = 1'b1;
            next_r.kind      = cmd_mbx_kind;
         end else if (cmd_pd) begin
            next_r.pd_valid = 1'b1;
            next_r.pd_out   = cmd_pd_out;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r        <= '0;
         r.target <= SWSM_ST_INIT;
      end else begin
         r <= next_r;
      end
   end

   assign lnk.reg_wr    = r.wr;
   assign lnk.reg_rd    = r.rd;
   assign lnk.reg_addr  = r.addr;
   assign lnk.reg_wdata = r.wdata;
   assign lnk.st_req    = r.st_req;
   assign lnk.st_target = r.target;
   assign lnk.mbx_cfg   = r.mbx_cfg;
   assign lnk.pd_cfg    = r.pd_cfg;
   assign lnk.mbx_valid = r.mbx_valid;
   assign lnk.mbx_kind  = r.kind;
   assign lnk.pd_valid  = r.pd_valid;
   assign lnk.pd_out    = r.pd_out;
   assign busy          = r.busy;
   assign rd_data       = r.rdata;
   assign state_refused = r.refused;

endmodule

// >>> hdl/swsm_slave.sv
// Purpose: slave controller watchdogs and operating state machine
// Assumes: master keeps its own duties, one request at a time
// Notes:   outputs fall to safe value while a watchdog is tripped
// Operation
// - two watchdogs, bus and local, default 100ms
// - shared prescaler register sets tick length
// - each watchdog has own timer register
// - tick is prescaler plus two base periods
// - master writes timings only when enabled
// - process data access restarts bus watchdog
// - bus expiry flags, state unchanged
// - expiry drives outputs to safe value
// - local watchdog trips on local silence
// - bus timer zero disables that watchdog
// - timer counts up to 65535 accepted
// - power-on init state refuses all traffic
// - master sets mailbox channels in init
// - init to configuring checks mailbox setup
// - configuring allows mailbox, no process data
// - inputs-only entry checks, copies inputs first
// - inputs-only: traffic allowed, outputs held safe
// - bus watchdog disabled lets outputs drive
// - master gives valid outputs before running
// - running applies master outputs, all traffic
// - boot only from init, file mailbox
`timescale 1ns/1ps
module swsm_slave
   import swsm_pkg::*;
#(
   parameter logic [15:0] SAFE_VALUE = 16'h0000
)(
   input  wire logic        clk,
   input  wire logic        rstn,
   swsm_if.slave            lnk,
   input  wire logic        local_access,
   input  wire logic [15:0] local_inputs,
   output logic [15:0]      outputs,
   output logic             local_wd_trig
);

   typedef struct packed {
      logic [15:0] prescaler;
      logic [15:0] local_time;
      logic [15:0] bus_time;
      logic        half;
      logic [16:0] pre_cnt;
      logic [15:0] bus_cnt;
      logic [15:0] loc_cnt;
      logic        bus_trig;
      logic        loc_trig;
      swsm_state_t st;
      logic        done;
      logic        refused;
      logic [15:0] rdata;
      logic        ack;
      logic [15:0] out_data;
      logic        have_out;
      logic [15:0] in_data;
      logic        mbx_taken;
      logic        pd_taken;
      logic [15:0] outs;
   } swsm_slv_t;

   swsm_slv_t r;
   swsm_slv_t next_r;

   function automatic logic [15:0] wd_step(input logic [15:0] cnt, input logic [15:0] lim);
      wd_step = (cnt < lim) ? cnt + 16'h0001 : cnt;
   endfunction

   logic tick;
   logic mbx_ok;
   logic pd_ok;
   logic bus_en;
   logic loc_en;
   logic drive_ok;

   always_comb begin
      // base tick runs at 25 MHz; watchdog tick every prescaler+2 base ticks
      // at-or-above compare: a prescaler lowered under the running count must not wait for a wrap
      // one spare bit so the largest prescaler still gets its full prescaler+2 base ticks
      tick   = r.half && (r.pre_cnt >= {1'b0, r.prescaler} + {1'b0, SWSM_TICK_EXTRA} - 17'h0_0001);
      bus_en = (r.bus_time != 16'h0000);
      loc_en = (r.local_time != 16'h0000);
      mbx_ok = lnk.mbx_valid && (r.st == SWSM_ST_CONF || r.st == SWSM_ST_INPUT || r.st == SWSM_ST_RUN ||
               (r.st == SWSM_ST_BOOT && lnk.mbx_kind == SWSM_MB_FILE));
      pd_ok  = lnk.pd_valid && (r.st == SWSM_ST_INPUT || r.st == SWSM_ST_RUN);
   end

   always_comb begin
      next_r           = r;
      next_r.ack       = 1'b0;
      next_r.done      = 1'b0;
      next_r.refused   = 1'b0;
      next_r.mbx_taken = mbx_ok;
      next_r.pd_taken  = pd_ok;
      next_r.half      = ~r.half;
      if (r.half) begin
         next_r.pre_cnt = tick ? 17'h0_0000 : r.pre_cnt + 17'h0_0001;
      end
      // register port; prescaler and timers are full 16 bits
      if (lnk.reg_wr) begin
         next_r.ack = 1'b1;
         unique case (lnk.reg_addr)
            SWSM_ADDR_PRESCALER: next_r.prescaler  = lnk.reg_wdata;
            SWSM_ADDR_LOCAL_WD:  next_r.local_time = lnk.reg_wdata;
            SWSM_ADDR_BUS_WD:    next_r.bus_time   = lnk.reg_wdata;
            default: ;
         endcase
      end else if (lnk.reg_rd) begin
         next_r.ack = 1'b1;
         unique case (lnk.reg_addr)
            SWSM_ADDR_PRESCALER: next_r.rdata = r.prescaler;
            SWSM_ADDR_LOCAL_WD:  next_r.rdata = r.local_time;
            SWSM_ADDR_BUS_WD:    next_r.rdata = r.bus_time;
            SWSM_ADDR_STATUS:    next_r.rdata = {11'h000, r.loc_trig, r.bus_trig, r.st};
            default:             next_r.rdata = 16'h0000;
         endcase
      end
      // bus watchdog: a process data access restarts and clears it; a zero bus timer also clears the trip
      if (pd_ok) begin
         next_r.bus_cnt  = 16'h0000;
         next_r.bus_trig = 1'b0;
         next_r.out_data = lnk.pd_out;
         next_r.have_out = 1'b1;
      end else if (tick && bus_en) begin
         next_r.bus_cnt = wd_step(r.bus_cnt, r.bus_time);
         if (r.bus_cnt + 16'h0001 >= r.bus_time) begin
            next_r.bus_trig = 1'b1;
         end
      end
      if (!bus_en) begin
         next_r.bus_trig = 1'b0;
      end
      if (local_access) begin
         next_r.loc_cnt  = 16'h0000;
         next_r.loc_trig = 1'b0;
      end else if (tick && loc_en) begin
         next_r.loc_cnt = wd_step(r.loc_cnt, r.local_time);
         if (r.loc_cnt + 16'h0001 >= r.local_time) begin
            next_r.loc_trig = 1'b1;
         end
      end
      if (r.st == SWSM_ST_INPUT || r.st == SWSM_ST_RUN) begin
         next_r.in_data = local_inputs;
      end
      // state requests; watchdog trips never move the state
      if (lnk.st_req) begin
         next_r.done = 1'b1;
         unique case (lnk.st_target)
            SWSM_ST_INIT: next_r.st = SWSM_ST_INIT;
            SWSM_ST_CONF: begin
               if ((r.st == SWSM_ST_INIT && lnk.mbx_cfg) ||
                   r.st inside {SWSM_ST_CONF, SWSM_ST_INPUT, SWSM_ST_RUN}) begin
                  next_r.st = SWSM_ST_CONF;
               end else begin
                  next_r.refused = 1'b1;
               end
            end
            SWSM_ST_BOOT: begin
               if (r.st == SWSM_ST_INIT && lnk.mbx_cfg) begin
                  next_r.st = SWSM_ST_BOOT;
               end else begin
                  next_r.refused = 1'b1;
               end
            end
            SWSM_ST_INPUT: begin
               if ((r.st == SWSM_ST_CONF && lnk.pd_cfg) || r.st == SWSM_ST_RUN) begin
                  next_r.st      = SWSM_ST_INPUT;
                  next_r.in_data = local_inputs;
               end else begin
                  next_r.refused = 1'b1;
               end
            end
            SWSM_ST_RUN: begin
               if (r.st == SWSM_ST_INPUT && r.have_out) begin
                  next_r.st = SWSM_ST_RUN;
               end else begin
                  next_r.refused = 1'b1;
               end
            end
            default: next_r.refused = 1'b1;
         endcase
         if (next_r.st == SWSM_ST_INIT || next_r.st == SWSM_ST_CONF) begin
            next_r.have_out = 1'b0;
         end
      end
      // outputs are worked out from the next state so the register follows it without lag
      drive_ok    = (next_r.st == SWSM_ST_RUN || (next_r.st == SWSM_ST_INPUT && next_r.bus_time == 16'h0000)) &&
                    next_r.have_out;
      next_r.outs = (drive_ok && !next_r.bus_trig && !next_r.loc_trig) ? next_r.out_data : SAFE_VALUE;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r            <= '0;
         r.prescaler  <= SWSM_RST_PRESCALER;
         r.local_time <= SWSM_RST_LOCAL_WD;
         r.bus_time   <= SWSM_RST_BUS_WD;
         r.st         <= SWSM_ST_INIT;
         r.outs       <= SAFE_VALUE;
      end else begin
         r <= next_r;
      end
   end

   assign outputs         = r.outs;
   assign local_wd_trig   = r.loc_trig;
   assign lnk.bus_wd_trig = r.bus_trig;
   assign lnk.reg_rdata   = r.rdata;
   assign lnk.reg_ack     = r.ack;
   assign lnk.st_cur      = r.st;
   assign lnk.st_done     = r.done;
   assign lnk.st_refused  = r.refused;
   assign lnk.mbx_taken   = r.mbx_taken;
   assign lnk.pd_taken    = r.pd_taken;
   assign lnk.pd_in       = r.in_data;

endmodule

// >>> inc/swsm_if.sv
// Purpose: link between fieldbus master and slave controller
// Assumes: single clock, all signals synchronous
// Notes:   master drives requests, slave answers
`timescale 1ns/1ps
interface swsm_if;
   import swsm_pkg::*;
   logic            reg_wr;
   logic            reg_rd;
   logic [15:0]     reg_addr;
   logic [15:0]     reg_wdata;
   logic [15:0]     reg_rdata;
   logic            reg_ack;
   logic            st_req;
   swsm_state_t     st_target;
   swsm_state_t     st_cur;
   logic            st_done;
   logic            st_refused;
   logic            mbx_cfg;
   logic            pd_cfg;
   logic            mbx_valid;
   swsm_mbx_kind_t  mbx_kind;
   logic            mbx_taken;
   logic            pd_valid;
   logic [15:0]     pd_out;
   logic            pd_taken;
   logic [15:0]     pd_in;
   logic            bus_wd_trig;

   modport slave  (input  reg_wr, reg_rd, reg_addr, reg_wdata, st_req, st_target, mbx_cfg, pd_cfg,
                          mbx_valid, mbx_kind, pd_valid, pd_out,
                   output reg_rdata, reg_ack, st_cur, st_done, st_refused, mbx_taken, pd_taken, pd_in,
                          bus_wd_trig);
   modport master (output reg_wr, reg_rd, reg_addr, reg_wdata, st_req, st_target, mbx_cfg, pd_cfg,
                          mbx_valid, mbx_kind, pd_valid, pd_out,
                   input  reg_rdata, reg_ack, st_cur, st_done, st_refused, mbx_taken, pd_taken, pd_in,
                          bus_wd_trig);
endinterface

// >>> inc/swsm_pkg.sv
// Purpose: shared constants and types for the slave watchdog and state machine link
// Assumes: 50 MHz system clock, watchdog base tick of 25 MHz emulated by a /2 enable
// Notes:   register map offsets are the slave's own byte offsets
package swsm_pkg;

   localparam logic [15:0] SWSM_ADDR_PRESCALER = 16'h0400;
   localparam logic [15:0] SWSM_ADDR_LOCAL_WD  = 16'h0410;
   localparam logic [15:0] SWSM_ADDR_BUS_WD    = 16'h0420;
   localparam logic [15:0] SWSM_ADDR_STATUS    = 16'h0130;

   localparam logic [15:0] SWSM_RST_PRESCALER  = 16'h09c2;
   localparam logic [15:0] SWSM_RST_LOCAL_WD   = 16'h03e8;
   localparam logic [15:0] SWSM_RST_BUS_WD     = 16'h03e8;

   localparam int          SWSM_CLK_MHZ        = 50;
   localparam int          SWSM_BASE_MHZ       = 25;
   localparam int          SWSM_BASE_DIV       = SWSM_CLK_MHZ / SWSM_BASE_MHZ;
   localparam logic [15:0] SWSM_TICK_EXTRA     = 16'h0002;

   // requested / current state codes as carried on the link
   typedef enum logic [2:0] {
      SWSM_ST_INIT  = 3'h1,
      SWSM_ST_CONF  = 3'h2,
      SWSM_ST_BOOT  = 3'h3,
      SWSM_ST_INPUT = 3'h4,
      SWSM_ST_RUN   = 3'h5
   } swsm_state_t;

   typedef enum logic [1:0] {
      SWSM_MB_GENERIC = 2'h0,
      SWSM_MB_FILE    = 2'h1
   } swsm_mbx_kind_t;

endpackage

// >>> sim/slave_watchdog_state_machine_tb_top.sv
// Purpose: self-checking bench for master and slave ends together
// Assumes: 50 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   short watchdog timings are written to keep the run small
`timescale 1ns/1ps
module slave_watchdog_state_machine_tb_top;
   import swsm_pkg::*;
   localparam logic [15:0] SAFE = 16'h5a5a;
   // short watchdog settings written mid-run so a trip takes at most 12 cycles
   localparam logic [15:0] WD_PRE = 16'h0000;
   localparam logic [15:0] WD_TMR = 16'h0003;
   logic           clk, rstn, local_access, ltrip, busy, refused, ref_q;
   logic           cmd_reg_wr, cmd_reg_rd, cmd_state, cmd_mbx, cmd_pd, cfg_write_timing;
   logic [15:0]    local_inputs, outputs, rd_data, cmd_addr, cmd_wdata, cmd_pd_out, last_pd;
   swsm_state_t    cmd_target;
   swsm_mbx_kind_t cmd_mbx_kind;
   int             bad_count = 0, num_checks = 0, n_pd = 0, n_mbx = 0;
   logic [15:0]    ra[5] = '{SWSM_ADDR_PRESCALER, SWSM_ADDR_LOCAL_WD, SWSM_ADDR_BUS_WD, SWSM_ADDR_STATUS, 16'h0500};
   logic [15:0]    rv[5] = '{SWSM_RST_PRESCALER, SWSM_RST_LOCAL_WD, SWSM_RST_BUS_WD, 16'h0001, 16'h0000};
   swsm_if lnk ();
   swsm_slave #(.SAFE_VALUE(SAFE)) swsm_slave_inst (.clk(clk), .rstn(rstn), .lnk(lnk),
      .local_access(local_access), .local_inputs(local_inputs), .outputs(outputs), .local_wd_trig(ltrip));
   swsm_master swsm_master_inst (.clk(clk), .rstn(rstn), .lnk(lnk), .cmd_reg_wr(cmd_reg_wr),
      .cmd_reg_rd(cmd_reg_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_state(cmd_state),
      .cmd_target(cmd_target), .cmd_mbx(cmd_mbx), .cmd_mbx_kind(cmd_mbx_kind), .cmd_pd(cmd_pd),
      .cmd_pd_out(cmd_pd_out), .cfg_write_timing(cfg_write_timing), .busy(busy), .rd_data(rd_data),
      .state_refused(refused));
   swsm_chk swsm_chk_inst (.clk(clk), .rstn(rstn), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
      .reg_ack(lnk.reg_ack), .st_req(lnk.st_req), .st_cur(lnk.st_cur), .st_done(lnk.st_done),
      .st_refused(lnk.st_refused), .mbx_valid(lnk.mbx_valid), .mbx_kind(lnk.mbx_kind),
      .mbx_taken(lnk.mbx_taken), .pd_valid(lnk.pd_valid), .pd_taken(lnk.pd_taken),
      .bus_wd_trig(lnk.bus_wd_trig));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (lnk.pd_taken === 1'b1) n_pd <= n_pd + 1;
      if (lnk.mbx_taken === 1'b1) n_mbx <= n_mbx + 1;
   end
   function automatic logic [15:0] status(swsm_state_t s, logic bt, logic lt);
      return {11'h000, lt, bt, s};
   endfunction
   function automatic logic can_mbx(swsm_state_t s, swsm_mbx_kind_t k);
      return s != SWSM_ST_INIT && (s != SWSM_ST_BOOT || k == SWSM_MB_FILE);
   endfunction
   // n edges from restart to trip; tick phase is free, so the trip lands within one tick's spread
   function automatic logic span_ok(int n);
      int tk;
      tk = SWSM_BASE_DIV * (int'(WD_PRE) + int'(SWSM_TICK_EXTRA));
      return n > (int'(WD_TMR) - 1) * tk && n <= int'(WD_TMR) * tk;
   endfunction
   task automatic complete_run;
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         $display("[FAIL] %0t %s", $time, msg);
         bad_count++;
      end
   endtask
   task automatic give_up;
      $display("[FAIL] %0t wait ran out", $time);
      bad_count++;
      complete_run;
   endtask
   // k: 0 write, 1 read, 2 state, 3 mailbox, 4 process data
   task automatic cmd(input int k, input logic [15:0] a, input logic [15:0] d,
                      input swsm_state_t t = SWSM_ST_INIT, input swsm_mbx_kind_t mk = SWSM_MB_GENERIC);
      int i;
      cmd_addr     = a;
      cmd_wdata    = d;
      cmd_pd_out   = d;
      cmd_target   = t;
      cmd_mbx_kind = mk;
      {cmd_pd, cmd_mbx, cmd_state, cmd_reg_rd, cmd_reg_wr} = 5'b00001 << k;
      @(posedge clk);
      #1;
      {cmd_pd, cmd_mbx, cmd_state, cmd_reg_rd, cmd_reg_wr} = 5'b00000;
      for (i = 0; i < 20 && busy !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      if (busy !== 1'b0) give_up();
      ref_q = refused;
      // two more edges so taken pulses land in the counters
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      cmd(1, a, 16'h0000);
      chk(rd_data, e, "register read");
   endtask
   task automatic go(input swsm_state_t t, input swsm_state_t e, input logic r);
      cmd(2, 16'h0000, 16'h0000, t);
      chk(16'(ref_q), 16'(r), "refusal flag");
      chk(16'(lnk.st_cur), 16'(e), "state");
   endtask
   task automatic traffic(input swsm_state_t s);
      int p, m;
      p = n_pd;
      m = n_mbx;
      last_pd = 16'($urandom);
      cmd(3, 16'h0000, 16'h0000, SWSM_ST_INIT, SWSM_MB_GENERIC);
      cmd(3, 16'h0000, 16'h0000, SWSM_ST_INIT, SWSM_MB_FILE);
      cmd(4, 16'h0000, last_pd);
      chk(16'(n_mbx - m), 16'(can_mbx(s, SWSM_MB_GENERIC)) + 16'(can_mbx(s, SWSM_MB_FILE)), "mailbox");
      chk(16'(n_pd - p), 16'(s inside {SWSM_ST_INPUT, SWSM_ST_RUN}), "process data");
   endtask
   // off: edges already gone by between the restart and the first polled edge
   task automatic wait_hi(input int w, input int off);
      int i;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if ((w == 0 ? lnk.bus_wd_trig : ltrip) === 1'b1) begin
            chk(16'(span_ok(i + 1 + off)), 16'h0001, "watchdog time");
            return;
         end
      end
      give_up();
   endtask
   initial begin
      {rstn, cmd_reg_wr, cmd_reg_rd, cmd_state, cmd_mbx, cmd_pd} = 6'b000000;
      {cmd_addr, cmd_wdata, cmd_pd_out} = {16'h0000, 16'h0000, 16'h0000};
      cmd_target       = SWSM_ST_INIT;
      cmd_mbx_kind     = SWSM_MB_GENERIC;
      local_access     = 1'b1;
      cfg_write_timing = 1'b1;
      void'($urandom(83));
      local_inputs = 16'($urandom);
      repeat (20) @(posedge clk);
      #1;
      rstn = 1'b1;
      for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
      traffic(SWSM_ST_INIT);
      chk(outputs, SAFE, "outputs not safe in init");
      go(SWSM_ST_RUN, SWSM_ST_INIT, 1'b1);
      go(SWSM_ST_BOOT, SWSM_ST_BOOT, 1'b0);
      traffic(SWSM_ST_BOOT);
      go(SWSM_ST_CONF, SWSM_ST_BOOT, 1'b1);
      rstn = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rstn = 1'b1;
      chk(16'(lnk.st_cur), 16'(SWSM_ST_INIT), "state after reset");
      go(SWSM_ST_CONF, SWSM_ST_CONF, 1'b0);
      traffic(SWSM_ST_CONF);
      go(SWSM_ST_BOOT, SWSM_ST_CONF, 1'b1);
      local_inputs = 16'($urandom);
      go(SWSM_ST_INPUT, SWSM_ST_INPUT, 1'b0);
      chk(lnk.pd_in, local_inputs, "input snapshot");
      traffic(SWSM_ST_INPUT);
      chk(outputs, SAFE, "outputs not safe in inputs-only");
      local_inputs = 16'($urandom);
      repeat (2) @(posedge clk);
      #1;
      chk(lnk.pd_in, local_inputs, "inputs not refreshed");
      go(SWSM_ST_RUN, SWSM_ST_RUN, 1'b0);
      repeat (4) begin
         traffic(SWSM_ST_RUN);
         chk(outputs, last_pd, "outputs in running");
      end
      cfg_write_timing = 1'b0;
      cmd(0, SWSM_ADDR_PRESCALER, 16'h0000);
      rd(SWSM_ADDR_PRESCALER, SWSM_RST_PRESCALER);
      cfg_write_timing = 1'b1;
      cmd(0, SWSM_ADDR_PRESCALER, WD_PRE);
      cmd(0, SWSM_ADDR_BUS_WD, WD_TMR);
      cmd(0, SWSM_ADDR_LOCAL_WD, 16'hffff);
      rd(SWSM_ADDR_LOCAL_WD, 16'hffff);
      cmd(0, SWSM_ADDR_LOCAL_WD, WD_TMR);
      rd(SWSM_ADDR_BUS_WD, WD_TMR);
      traffic(SWSM_ST_RUN);
      chk(16'(lnk.bus_wd_trig), 16'h0000, "trip right after access");
      wait_hi(0, 1);
      chk(16'(lnk.st_cur), 16'(SWSM_ST_RUN), "trip changed state");
      chk(outputs, SAFE, "outputs not safe on trip");
      traffic(SWSM_ST_RUN);
      chk(16'(lnk.bus_wd_trig), 16'h0000, "trip not cleared");
      chk(outputs, last_pd, "outputs after clear");
      cmd(0, SWSM_ADDR_BUS_WD, 16'h0000);
      repeat (40) @(posedge clk);
      #1;
      chk(16'(lnk.bus_wd_trig), 16'h0000, "disabled watchdog tripped");
      go(SWSM_ST_INPUT, SWSM_ST_INPUT, 1'b0);
      traffic(SWSM_ST_INPUT);
      chk(outputs, last_pd, "outputs held with watchdog off");
      // local silence: access line dropped so only the local timer runs
      local_access = 1'b0;
      wait_hi(1, 0);
      chk(outputs, SAFE, "outputs not safe on local trip");
      rd(SWSM_ADDR_STATUS, status(SWSM_ST_INPUT, 1'b0, 1'b1));
      local_access = 1'b1;
      complete_run();
   end
endmodule

// >>> sim/swsm_chk.sv
// Purpose: link checks between master and slave ends
// Assumes: one clock, rstn async active low
// Notes:   watches link signals only, both ends are design code
`timescale 1ns/1ps
module swsm_chk
   import swsm_pkg::*;
(
   input logic           clk,
   input logic           rstn,
   input logic           reg_wr,
   input logic           reg_rd,
   input logic           reg_ack,
   input logic           st_req,
   input swsm_state_t    st_cur,
   input logic           st_done,
   input logic           st_refused,
   input logic           mbx_valid,
   input swsm_mbx_kind_t mbx_kind,
   input logic           mbx_taken,
   input logic           pd_valid,
   input logic           pd_taken,
   input logic           bus_wd_trig
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_reg_ack; (reg_wr || reg_rd) |=> reg_ack; endproperty
   a_reg_ack: assert property (p_reg_ack) else $error("register access not acknowledged");
   property p_st_done; st_req |=> st_done; endproperty
   a_st_done: assert property (p_st_done) else $error("state request not answered");
   property p_refuse_keep; st_done && st_refused |-> st_cur == $past(st_cur); endproperty
   a_refuse_keep: assert property (p_refuse_keep) else $error("refused change moved state");
   property p_init_quiet;
      st_cur == SWSM_ST_INIT && (pd_valid || mbx_valid) |=> !(pd_taken || mbx_taken);
   endproperty
   a_init_quiet: assert property (p_init_quiet) else $error("traffic taken in init");
   property p_conf_nopd; st_cur == SWSM_ST_CONF && pd_valid |=> !pd_taken; endproperty
   a_conf_nopd: assert property (p_conf_nopd) else $error("process data taken in configuring");
   property p_boot_mbx;
      st_cur == SWSM_ST_BOOT && mbx_valid |=> mbx_taken == ($past(mbx_kind) == SWSM_MB_FILE);
   endproperty
   a_boot_mbx: assert property (p_boot_mbx) else $error("wrong mailbox handling in boot");
   property p_boot_entry; $changed(st_cur) && st_cur == SWSM_ST_BOOT |-> $past(st_cur) == SWSM_ST_INIT; endproperty
   a_boot_entry: assert property (p_boot_entry) else $error("boot entered from non-init");
   property p_pd_ok; pd_valid && st_cur inside {SWSM_ST_INPUT, SWSM_ST_RUN} |=> pd_taken; endproperty
   a_pd_ok: assert property (p_pd_ok) else $error("process data not taken");
   property p_trip_keep; $rose(bus_wd_trig) |-> $stable(st_cur); endproperty
   a_trip_keep: assert property (p_trip_keep) else $error("trip changed state");
   property p_trip_clear; $fell(bus_wd_trig) |-> pd_taken || $past(pd_taken); endproperty
   a_trip_clear: assert property (p_trip_clear) else $error("trip cleared without access");
   c_refused: cover property (st_done && st_refused);
   c_trip: cover property ($rose(bus_wd_trig));
   c_boot_file: cover property (st_cur == SWSM_ST_BOOT && mbx_taken);
endmodule
